// [hw/wdt_defines.vh]
// register map, field positions, reset values and timing counts of the watchdog
`ifndef WDT_DEFINES_VH
`define WDT_DEFINES_VH

// byte addresses
`define WDT_CTRL_OFFSET 12'h000
`define WDT_RESTART_OFFSET 12'h004

// control register fields
`define WDT_IRQ_FLAG_BIT 7
`define WDT_IRQ_EN_BIT 6
`define WDT_PS3_BIT 5
`define WDT_CE_BIT 4
`define WDT_RST_EN_BIT 3
`define WDT_PS2_BIT 2
`define WDT_PS1_BIT 1
`define WDT_PS0_BIT 0

// reset values
`define WDT_IRQ_EN_RST 1'b0
`define WDT_RST_EN_RST 1'b0
`define WDT_PS_RST 4'h0

// prescale codes and timeouts in oscillator cycles
`define WDT_PS_MAX 4'h9
`define WDT_BASE_CYCLES 21'h000800
`define WDT_CNT_W 21

// change-enable lifetime in pclk cycles
`define WDT_CE_CYCLES 3'h4

// oscillator nominal rate in kHz
`define WDT_OSC_KHZ 128

`endif

// [hw/windowless_watchdog_timer.v]
// watchdog timer with apb control register, timed change protection and modes
//
// Contract
// - expiry in interrupt mode sets flag bit7
// - executing vector clears the flag
// - write one clears flag, zero keeps
// - request when flag, enable, global enable
// - enables select stopped/irq/reset/combined mode
// - combined mode: vector clears enable and flag
// - combined mode: second unserviced expiry resets
// - clock monitor forces reset, disables interrupt
// - clock monitor with any enable: reset only
// - reset-enable clear, prescale change need change-enable
// - change-enable self clears four cycles later
// - reset flag forces reset enable to one
// - prescale codes select 2048 to 1048576 cycles
// - counter runs on separate 128 kHz oscillator
// - restart instruction clears counter to zero
// - fuse forces reset enable one, irq zero
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defines.vh"

module windowless_watchdog_timer (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // watchdog oscillator pin
   input wire wdt_osc,
   // core and system side
   input wire restart_exec,
   input wire vector_exec,
   input wire global_irq_enable,
   input wire watchdog_reset_flag,
   input wire always_on_fuse,
   input wire clock_monitor_on,
   // requests
   output reg irq_req,
   output reg reset_req
);

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // last count before expiry for a prescale code
   function [`WDT_CNT_W-1:0] last_count;
      input [3:0] sel;
      reg [3:0] s;
      begin
         s = (sel > `WDT_PS_MAX) ? `WDT_PS_MAX : sel;
         last_count = (`WDT_BASE_CYCLES << s) - 21'h000001;
      end
   endfunction

   // address compare against a register offset
   function addr_is;
      input [11:0] a;
      input [11:0] target;
      begin
         addr_is = (a == target);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // state

   reg pready_ff;
   reg [31:0] prdata_ff;
   reg pslverr_ff;
   reg osc_s1_ff;
   reg osc_s2_ff;
   reg osc_s3_ff;
   reg osc_lvl_ff;
   reg [`WDT_CNT_W-1:0] count_ff;
   reg flag_ff;
   reg irq_en_ff;
   reg rst_en_ff;
   reg ce_ff;
   reg [2:0] ce_cnt_ff;
   reg [3:0] ps_ff;
   reg irq_req_ff;
   reg reset_req_ff;

   reg [`WDT_CNT_W-1:0] nxt_count;
   reg nxt_osc_lvl;
   reg nxt_flag;
   reg nxt_irq_en;
   reg nxt_rst_en;
   reg nxt_ce;
   reg [2:0] nxt_ce_cnt;
   reg [3:0] nxt_ps;
   reg nxt_irq_req;
   reg nxt_reset_req;
   reg nxt_pready;
   reg [31:0] nxt_prdata;
   reg nxt_pslverr;

   // byte lane 0 write of a decoded address
   function wr_hit;
      input [11:0] a;
      input [11:0] target;
      begin
         wr_hit = psel & penable & pready_ff & pwrite & pstrb[0] & addr_is(a, target);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // decode

   wire ctrl_wr;
   wire restart_wr;
   wire addr_ok;
   wire osc_tick;
   wire expire;
   wire [7:0] ctrl_view;
   wire [3:0] wr_ps;
   wire access_phase;

   assign ctrl_wr = wr_hit(paddr, `WDT_CTRL_OFFSET);
   assign restart_wr = wr_hit(paddr, `WDT_RESTART_OFFSET);
   assign addr_ok = addr_is(paddr, `WDT_CTRL_OFFSET) | addr_is(paddr, `WDT_RESTART_OFFSET);
   assign access_phase = psel & penable & ~pready_ff;
   assign wr_ps = {pwdata[`WDT_PS3_BIT], pwdata[`WDT_PS2_BIT],
                   pwdata[`WDT_PS1_BIT], pwdata[`WDT_PS0_BIT]};

   ////////////////////////////////////////////////////////////////////////////
   // mode selection

   wire rst_en_eff;
   wire irq_mode;
   wire rst_mode;
   wire stopped;

   // reset flag and fuse hold enable
   assign rst_en_eff = rst_en_ff | watchdog_reset_flag | always_on_fuse;
   assign irq_mode = irq_en_ff & ~always_on_fuse & ~clock_monitor_on;
   assign rst_mode = rst_en_eff | (clock_monitor_on & irq_en_ff);
   assign stopped = ~irq_mode & ~rst_mode;

   assign ctrl_view = {flag_ff, irq_en_ff & ~always_on_fuse, ps_ff[3], ce_ff,
                       rst_en_eff, ps_ff[2:0]};

   ////////////////////////////////////////////////////////////////////////////
   // oscillator edge detect

   // ticks come from the separate oscillator
   assign osc_tick = osc_lvl_ff & ~nxt_osc_lvl ? 1'b0 : (~osc_lvl_ff & nxt_osc_lvl);

   always @* begin
      nxt_osc_lvl = osc_lvl_ff;
      if (osc_s2_ff == osc_s3_ff) begin
         nxt_osc_lvl = osc_s3_ff;
      end
   end

   // timeout length from prescale code
   // a count already past a shortened limit expires on the next oscillator tick
   assign expire = osc_tick & ~stopped & (count_ff >= last_count(ps_ff));

   ////////////////////////////////////////////////////////////////////////////
   // counter

   always @* begin
      nxt_count = count_ff;
      if (restart_exec | restart_wr | stopped) begin
         nxt_count = {`WDT_CNT_W{1'b0}};
      end else if (expire) begin
         nxt_count = {`WDT_CNT_W{1'b0}};
      end else if (osc_tick) begin
         nxt_count = count_ff + 21'h000001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control register

   always @* begin
      nxt_flag = flag_ff;
      nxt_irq_en = irq_en_ff;
      nxt_rst_en = rst_en_ff;
      nxt_ce = ce_ff;
      nxt_ce_cnt = ce_cnt_ff;
      nxt_ps = ps_ff;
      nxt_reset_req = 1'b0;
      if (ce_ff) begin
         if (ce_cnt_ff == 3'h1) begin
            nxt_ce = 1'b0;
            nxt_ce_cnt = 3'h0;
         end else begin
            nxt_ce_cnt = ce_cnt_ff - 3'h1;
         end
      end
      if (ctrl_wr) begin
         if (pwdata[`WDT_IRQ_FLAG_BIT]) begin
            nxt_flag = 1'b0;
         end
         nxt_irq_en = pwdata[`WDT_IRQ_EN_BIT];
         if (pwdata[`WDT_RST_EN_BIT]) begin
            nxt_rst_en = 1'b1;
         end else if (ce_ff & ~watchdog_reset_flag) begin
            nxt_rst_en = 1'b0;
         end
         if (ce_ff) begin
            nxt_ps = wr_ps;
         end
         if (pwdata[`WDT_CE_BIT]) begin
            nxt_ce = 1'b1;
            nxt_ce_cnt = `WDT_CE_CYCLES;
         end else begin
            nxt_ce = 1'b0;
            nxt_ce_cnt = 3'h0;
         end
      end
      if (vector_exec) begin
         nxt_flag = 1'b0;
         // combined mode drops to reset only
         if (irq_mode & rst_mode) begin
            nxt_irq_en = 1'b0;
         end
      end
      if (expire) begin
         if (irq_mode & rst_mode & flag_ff) begin
            nxt_reset_req = 1'b1;
         end else if (irq_mode) begin
            // expiry sets flag, wins over clear
            nxt_flag = 1'b1;
         end else begin
            nxt_reset_req = 1'b1;
         end
      end
      nxt_irq_req = nxt_flag & nxt_irq_en & ~always_on_fuse & ~clock_monitor_on
                    & global_irq_enable;
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb answer

   always @* begin
      nxt_pready = access_phase;
      nxt_prdata = prdata_ff;
      nxt_pslverr = 1'b0;
      if (access_phase) begin
         nxt_pslverr = ~addr_ok;
         nxt_prdata = 32'h00000000;
         if (~pwrite & addr_is(paddr, `WDT_CTRL_OFFSET)) begin
            nxt_prdata = {24'h000000, ctrl_view};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb answer flops

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
         prdata_ff <= 32'h00000000;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff <= nxt_pready;
         prdata_ff <= nxt_prdata;
         pslverr_ff <= nxt_pslverr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // oscillator synchroniser flops

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_s1_ff <= 1'b0;
         osc_s2_ff <= 1'b0;
         osc_s3_ff <= 1'b0;
         osc_lvl_ff <= 1'b0;
      end else begin
         osc_s1_ff <= wdt_osc;
         osc_s2_ff <= osc_s1_ff;
         osc_s3_ff <= osc_s2_ff;
         osc_lvl_ff <= nxt_osc_lvl;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // watchdog state flops

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_ff <= {`WDT_CNT_W{1'b0}};
         flag_ff <= 1'b0;
         irq_en_ff <= `WDT_IRQ_EN_RST;
         rst_en_ff <= `WDT_RST_EN_RST;
         ce_ff <= 1'b0;
         ce_cnt_ff <= 3'h0;
         ps_ff <= `WDT_PS_RST;
         irq_req_ff <= 1'b0;
         reset_req_ff <= 1'b0;
      end else begin
         count_ff <= nxt_count;
         flag_ff <= nxt_flag;
         irq_en_ff <= nxt_irq_en;
         rst_en_ff <= nxt_rst_en;
         ce_ff <= nxt_ce;
         ce_cnt_ff <= nxt_ce_cnt;
         ps_ff <= nxt_ps;
         irq_req_ff <= nxt_irq_req;
         reset_req_ff <= nxt_reset_req;
      end
   end

   always @* begin
      pready = pready_ff;
      prdata = prdata_ff;
      pslverr = pslverr_ff;
      irq_req = irq_req_ff;
      reset_req = reset_req_ff;
   end

endmodule
`default_nettype wire

// [bench/windowless_watchdog_timer_checker.sv]
// port assertions of the watchdog timer
`timescale 1ns/1ps
`default_nettype none
module windowless_watchdog_timer_checker (
   // apb
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   // core side
   input wire global_irq_enable,
   input wire watchdog_reset_flag,
   input wire always_on_fuse,
   input wire clock_monitor_on,
   input wire irq_req,
   input wire reset_req
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("ready late");
   a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
   a_err_unmapped: assert property (pready |->
      pslverr == (paddr != 12'h000 && paddr != 12'h004)) else $error("bad error flag");
   a_read_upper: assert property (pready && !pwrite && !pslverr |-> prdata[31:8] == 24'h000000)
      else $error("upper bits set");
   a_restart_read: assert property (pready && !pwrite && paddr == 12'h004 |-> prdata == 32'h0)
      else $error("restart read nonzero");
   a_irq_gate: assert property (irq_req |-> $past(global_irq_enable)
      && !$past(always_on_fuse) && !$past(clock_monitor_on)) else $error("irq not gated");
   a_reset_pulse: assert property (reset_req |=> !reset_req)
      else $error("reset held");
   a_reset_en_forced: assert property (pready && !pwrite && paddr == 12'h000
      && ($past(watchdog_reset_flag) || $past(always_on_fuse)) |-> prdata[3])
      else $error("reset enable clear");
endmodule
bind windowless_watchdog_timer windowless_watchdog_timer_checker wdt_checker_i (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
   .global_irq_enable, .watchdog_reset_flag, .always_on_fuse, .clock_monitor_on,
   .irq_req, .reset_req);
`default_nettype wire

// [bench/windowless_watchdog_timer_tb_top.sv]
// self-checking bench of the watchdog timer
`timescale 1ns/1ps
`default_nettype none
module windowless_watchdog_timer_tb_top;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic wdt_osc = 1'b0, restart_exec = 1'b0, vector_exec = 1'b0, global_irq_enable = 1'b1;
   logic watchdog_reset_flag = 1'b0, always_on_fuse = 1'b0, clock_monitor_on = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rd;
   logic [3:0] pstrb = 4'hF;
   logic [1:0] osc_cnt = 2'h0;
   wire [31:0] prdata;
   wire pready, pslverr, irq_req, reset_req;
   int n_mismatch = 0, num_checks = 0, k, t;
   // code 0 timeout in pclk cycles, oscillator level lasts three
   localparam int tmo = 2048 * 6;
   windowless_watchdog_timer windowless_watchdog_timer_i (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .wdt_osc, .restart_exec,
      .vector_exec, .global_irq_enable, .watchdog_reset_flag, .always_on_fuse,
      .clock_monitor_on, .irq_req, .reset_req);
   initial forever #2 pclk = ~pclk;
   always @(posedge pclk) begin
      osc_cnt <= (osc_cnt == 2'h2) ? 2'h0 : osc_cnt + 2'h1;
      wdt_osc <= (osc_cnt == 2'h2) ? ~wdt_osc : wdt_osc;
   end
   function automatic logic [31:0] ctl(input logic [2:0] fer, input logic [3:0] ps);
      return {24'h000000, fer[2:1], ps[3], 1'b0, fer[0], ps[2:0]};
   endfunction
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task hang(input logic h);
      if (h) begin
         chk(32'h0, 32'h1);
         finish_test();
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
      input logic e, input logic b2b);
      int i;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      for (i = 0; i < 8 && pready !== 1'b1; i++) begin
         @(posedge pclk);
      end
      hang(i == 8);
      rd = prdata;
      chk({31'h0, pslverr}, {31'h0, e});
      penable <= 1'b0;
      if (!b2b) begin
         psel <= 1'b0;
         @(posedge pclk);
      end
   endtask
   task wr(input logic [11:0] a, input logic [7:0] d, input logic b2b);
      apb(1'b1, a, (32'($urandom) & 32'hFFFFFF00) | 32'(d), 4'($urandom) | 4'h1, 1'b0, b2b);
   endtask
   task rdc(input logic [11:0] a, input logic [31:0] exp, input logic e);
      apb(1'b0, a, 32'h0, 4'hF, e, 1'b0);
      if (!e) begin
         chk(rd, exp);
      end
   endtask
   task wait_hi(input logic w);
      for (t = 0; t < tmo + 200 && (w ? reset_req : irq_req) !== 1'b1; t++) begin
         @(posedge pclk);
      end
      hang(t == tmo + 200);
   endtask
   initial begin
      void'($urandom(32'hE037));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(12'h000, ctl(3'b000, 4'h0), 1'b0);
      for (k = 0; k < 3; k++) begin
         rdc(12'h008 + 12'($urandom % 1000) * 12'h004, 32'h0, 1'b1);
      end
      rdc(12'hFFC, 32'h0, 1'b1);
      rdc(12'h004, 32'h0, 1'b0);
      apb(1'b1, 12'h000, 32'h00000040, 4'hE, 1'b0, 1'b0);
      rdc(12'h000, ctl(3'b000, 4'h0), 1'b0);
      $display("test refusals done");
      wr(12'h004, 8'h00, 1'b0);
      wr(12'h000, 8'h40, 1'b0);
      wait_hi(1'b0);
      rdc(12'h000, ctl(3'b110, 4'h0), 1'b0);
      for (k = 0; k < 2; k++) begin
         {clock_monitor_on, always_on_fuse} <= k ? 2'b01 : 2'b10;
         repeat (2) @(posedge pclk);
         chk({31'h0, irq_req}, 32'h0);
      end
      {clock_monitor_on, always_on_fuse} <= 2'b00;
      global_irq_enable <= 1'b0;
      repeat (2) @(posedge pclk);
      chk({31'h0, irq_req}, 32'h0);
      global_irq_enable <= 1'b1;
      wr(12'h000, 8'h40, 1'b0);
      rdc(12'h000, ctl(3'b110, 4'h0), 1'b0);
      wr(12'h000, 8'hC0, 1'b0);
      rdc(12'h000, ctl(3'b010, 4'h0), 1'b0);
      $display("test interrupt mode done");
      repeat (1000) @(posedge pclk);
      restart_exec <= 1'b1;
      @(posedge pclk);
      restart_exec <= 1'b0;
      wr(12'h000, 8'h48, 1'b0);
      wait_hi(1'b0);
      chk({31'h0, t > tmo - 300}, 32'h1);
      chk({31'h0, reset_req}, 32'h0);
      wait_hi(1'b1);
      vector_exec <= 1'b1;
      @(posedge pclk);
      vector_exec <= 1'b0;
      rdc(12'h000, ctl(3'b001, 4'h0), 1'b0);
      wait_hi(1'b1);
      $display("test combined mode done");
      wr(12'h000, 8'h00, 1'b0);
      rdc(12'h000, ctl(3'b001, 4'h0), 1'b0);
      wr(12'h000, 8'h09, 1'b0);
      rdc(12'h000, ctl(3'b001, 4'h0), 1'b0);
      wr(12'h004, 8'h00, 1'b0);
      wr(12'h000, 8'h18, 1'b1);
      wr(12'h000, 8'h01, 1'b0);
      rdc(12'h000, ctl(3'b000, 4'h1), 1'b0);
      wr(12'h000, 8'h18, 1'b0);
      repeat (4) @(posedge pclk);
      wr(12'h000, 8'h00, 1'b0);
      rdc(12'h000, ctl(3'b001, 4'h1), 1'b0);
      watchdog_reset_flag <= 1'b1;
      wr(12'h000, 8'h18, 1'b1);
      wr(12'h000, 8'h00, 1'b0);
      rdc(12'h000, ctl(3'b001, 4'h0), 1'b0);
      watchdog_reset_flag <= 1'b0;
      rdc(12'h000, ctl(3'b001, 4'h0), 1'b0);
      $display("test protection done");
      wr(12'h000, 8'h18, 1'b1);
      wr(12'h000, 8'h40, 1'b0);
      for (k = 0; k < 2; k++) begin
         {clock_monitor_on, always_on_fuse} <= k ? 2'b01 : 2'b10;
         repeat (1000) @(posedge pclk);
         wr(12'h004, 8'h00, 1'b0);
         wait_hi(1'b1);
         chk({31'h0, t > tmo - 300}, 32'h1);
         chk({31'h0, irq_req}, 32'h0);
      end
      $display("test monitor and fuse done");
      finish_test();
   end
endmodule
`default_nettype wire
